// file: pkg/pmx_consts.vh
// constants for the port pin function multiplexer
// assumes 32-bit classic wishbone with byte addresses, register index * 4
`ifndef PMX_CONSTS_VH
`define PMX_CONSTS_VH
`define PMX_IDX_PORT_ONE 6'h11
`define PMX_IDX_PORT_TWO 6'h12
`define PMX_IDX_TEST_SEL 6'h35
`define PMX_IDX_STATUS 6'h36
`define PMX_RST_PORT_ONE 8'h06
`define PMX_RST_PORT_TWO 8'h00
`define PMX_RST_TEST_SEL 8'h00
`define PMX_P13_SEL_HI 7
`define PMX_P13_SEL_LO 5
`define PMX_P13_INV 4
`define PMX_P12_SEL_HI 3
`define PMX_P12_SEL_LO 1
`define PMX_P12_INV 0
`define PMX_SEPARATE_SERIAL_OUTPUT 7
`define PMX_SEP_RX 6
`define PMX_SEP_TX 5
`define PMX_P14_SEL_HI 2
`define PMX_P14_SEL_LO 1
`define PMX_P14_INV 0
`define PMX_TSEL_HI 6
`define PMX_TSEL_LO 4
`define PMX_C3_HIZ 3'h0
`define PMX_C3_ZERO 3'h1
`define PMX_C3_TWO 3'h2
`define PMX_C3_THREE 3'h3
`define PMX_C3_FOUR 3'h4
`define PMX_C3_FIVE 3'h5
`define PMX_C3_SIX 3'h6
`define PMX_C3_SEVEN 3'h7
`define PMX_C2_HIZ 2'h0
`define PMX_C2_LOW 2'h1
`define PMX_SYNC_W 28
`endif

// file: rtl/pmx_sync.v
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level or a clock well below clk_i / 2
`timescale 1ns/1ns
module pmx_sync #(
	parameter W = 1
) (
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta_r;
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

// file: rtl/pmx_pin.v
// registered pin driver: applies polarity inversion and output enable
// assumes drive_i and val_i are settled logic on clk_i
`timescale 1ns/1ns
module pmx_pin (
	input wire clk_i,
	input wire rst_i,
	input wire drive_i,
	input wire val_i,
	input wire inv_i,
	output reg pin_o,
	output reg pin_oe_o
);
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_o <= val_i ^ inv_i;
			pin_oe_o <= drive_i;
		end
	end
endmodule

// file: rtl/pmx_port_mux.v
// port pin function multiplexer with wishbone register access
// assumes internal status and clock signals arrive from other domains
// and are synchronised here; spi output data is on clk_i
`timescale 1ns/1ns
`include "pmx_consts.vh"
// Notes on behaviour
// - clock pin function from bits 3..1 of port one, bit 0 inverts.
// - clock pin codes: hi-z, zero, clock generator, pll feedback, poll clock.
// - code 010 gives tx bit clock or rx bit clock per separate lines.
// - codes 110 and 111 route test groups chosen by test select field.
// - group 110: four brown-outs, oscillator ready, kick A, kick C.
// - group 111: limiter Q, calibration, poll clock, rssi, locks, 1 MHz, low.
// - serial out pin codes: hi-z, zero, modulation, ready flags.
// - separate serial output bit forces hi-z or serial data output.
// - separate rx lines put rx data on data pin, rx clock on clock pin, unless separate tx is also live.
// - separate tx lines take tx data from data pin, tx clock out.
// - separate rx/tx bits clear the rx/tx on serial flags; data pin only while active.
// - indicator pin bits 2..1 select, bit 0 inverts, mode indication.
// - serial out pin invert sits at bit 4 of port one.
module pmx_port_mux (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire tx_active_i,
	input wire rx_active_i,
	input wire tx_bit_clk_i,
	input wire rx_bit_clk_i,
	input wire rx_data_i,
	input wire clkgen_out_i,
	input wire pll_fb_clk_i,
	input wire poll_clk_i,
	input wire tx_mod_i,
	input wire rx_ready_i,
	input wire tx_ready_i,
	input wire reference_clock_ready_i,
	input wire local_osc_ready_i,
	input wire [6:0] test_group_a_i,
	input wire [5:0] test_group_b_i,
	input wire serial_data_in_i,
	input wire spi_sdo_i,
	input wire spi_sdo_en_i,
	input wire data_pin_i,
	output wire data_pin_o,
	output wire data_pin_oe_o,
	output wire clock_pin_o,
	output wire clock_pin_oe_o,
	output wire serial_out_pin_o,
	output wire serial_out_pin_oe_o,
	output wire indicator_pin_o,
	output wire indicator_pin_oe_o,
	output reg tx_data_o,
	output reg rx_on_serial_o,
	output reg tx_on_serial_o
);
	reg [7:0] port_control_one_r;
	reg [7:0] port_control_two_r;
	reg [7:0] test_select_register_r;
	wire [`PMX_SYNC_W-1:0] async_in;
	wire [`PMX_SYNC_W-1:0] sy;
	wire bus_req;
	wire [5:0] reg_idx;
	reg [31:0] rd_nxt;

	// synchronised copies of the outside signals
	wire s_tx_active = sy[0];
	wire s_rx_active = sy[1];
	wire s_tx_bit_clk = sy[2];
	wire s_rx_bit_clk = sy[3];
	wire s_rx_data = sy[4];
	wire s_clkgen = sy[5];
	wire s_pll_fb = sy[6];
	wire s_poll_clk = sy[7];
	wire s_tx_mod = sy[8];
	wire s_rx_ready = sy[9];
	wire s_tx_ready = sy[10];
	wire s_refclk_ready = sy[11];
	wire s_lo_ready = sy[12];
	wire s_data_pin = sy[13];
	wire s_serial_in = sy[14];
	wire [6:0] s_test_a = sy[21:15];
	wire [5:0] s_test_b = sy[27:22];

	// register fields
	wire [2:0] clock_pin_function_select =
		port_control_one_r[`PMX_P12_SEL_HI:`PMX_P12_SEL_LO];
	wire clock_pin_invert = port_control_one_r[`PMX_P12_INV];
	wire [2:0] serial_out_pin_function_select =
		port_control_one_r[`PMX_P13_SEL_HI:`PMX_P13_SEL_LO];
	wire serial_out_pin_invert = port_control_one_r[`PMX_P13_INV];
	wire separate_serial_output = port_control_two_r[`PMX_SEPARATE_SERIAL_OUTPUT];
	wire separate_rx_lines = port_control_two_r[`PMX_SEP_RX];
	wire separate_tx_lines = port_control_two_r[`PMX_SEP_TX];
	wire [1:0] indicator_pin_function_select =
		port_control_two_r[`PMX_P14_SEL_HI:`PMX_P14_SEL_LO];
	wire indicator_pin_invert = port_control_two_r[`PMX_P14_INV];
	wire [2:0] test_signal_select =
		test_select_register_r[`PMX_TSEL_HI:`PMX_TSEL_LO];

	wire sep_rx_live = separate_rx_lines & s_rx_active;
	wire sep_tx_live = separate_tx_lines & s_tx_active;

	reg p10_drv;
	reg p10_val;
	reg p12_drv;
	reg p12_val;
	reg p12_test;
	reg p13_drv;
	reg p13_val;
	reg p13_inv;
	reg p14_drv;
	reg p14_val;

	assign async_in = {test_group_b_i, test_group_a_i, serial_data_in_i,
		data_pin_i, local_osc_ready_i, reference_clock_ready_i, tx_ready_i,
		rx_ready_i, tx_mod_i, poll_clk_i, pll_fb_clk_i, clkgen_out_i,
		rx_data_i, rx_bit_clk_i, tx_bit_clk_i, rx_active_i, tx_active_i};

	pmx_sync #(
		.W(`PMX_SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(async_in),
		.q_o(sy)
	);

	// wishbone slave: one wait state, ack drops the cycle after
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign reg_idx = adr_i[7:2];

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			port_control_one_r <= `PMX_RST_PORT_ONE;
			port_control_two_r <= `PMX_RST_PORT_TWO;
			test_select_register_r <= `PMX_RST_TEST_SEL;
		end else begin
			ack_o <= bus_req;
			if (bus_req) begin
				dat_o <= rd_nxt;
			end
			if (bus_req && we_i && sel_i[0]) begin
				case (reg_idx)
				`PMX_IDX_PORT_ONE: begin
					port_control_one_r <= dat_i[7:0];
				end
				`PMX_IDX_PORT_TWO: begin
					port_control_two_r <= dat_i[7:0];
				end
				`PMX_IDX_TEST_SEL: begin
					test_select_register_r <= dat_i[7:0];
				end
				default: begin
					port_control_one_r <= port_control_one_r;
				end
				endcase
			end
		end
	end

	// read mux; unmapped indexes answer zero
	always @* begin
		rd_nxt = 32'h00000000;
		case (reg_idx)
		`PMX_IDX_PORT_ONE: begin
			rd_nxt[7:0] = port_control_one_r;
		end
		`PMX_IDX_PORT_TWO: begin
			rd_nxt[7:0] = port_control_two_r;
		end
		`PMX_IDX_TEST_SEL: begin
			rd_nxt[7:0] = test_select_register_r;
		end
		`PMX_IDX_STATUS: begin
			rd_nxt[0] = s_tx_active;
			rd_nxt[1] = s_rx_active;
			rd_nxt[2] = sep_tx_live;
			rd_nxt[3] = sep_rx_live;
			rd_nxt[4] = data_pin_oe_o;
			rd_nxt[5] = clock_pin_oe_o;
			rd_nxt[6] = serial_out_pin_oe_o;
			rd_nxt[7] = indicator_pin_oe_o;
		end
		default: begin
			rd_nxt = 32'h00000000;
		end
		endcase
	end

	// test signal groups on the clock pin; the last member is held low
	wire [7:0] test_group_a = {1'h0, s_test_a};
	wire [7:0] test_group_b = {1'h0, s_test_b[5:2], s_poll_clk,
		s_test_b[1:0]};

	always @* begin
		p12_test = test_group_b[test_signal_select];
		if (clock_pin_function_select == `PMX_C3_SIX) begin
			p12_test = test_group_a[test_signal_select];
		end
	end

	// clock pin function
	always @* begin
		p12_drv = 1'b1;
		p12_val = 1'b0;
		case (clock_pin_function_select)
		`PMX_C3_HIZ: begin
			p12_drv = 1'b0;
		end
		`PMX_C3_ZERO: begin
			p12_val = 1'b0;
		end
		`PMX_C3_TWO: begin
			if (sep_tx_live) begin
				p12_val = s_tx_bit_clk;
			end else if (sep_rx_live) begin
				p12_val = s_rx_bit_clk;
			end else begin
				p12_drv = 1'b0;
			end
		end
		`PMX_C3_THREE: begin
			p12_val = s_clkgen;
		end
		`PMX_C3_FOUR: begin
			p12_val = s_pll_fb;
		end
		`PMX_C3_FIVE: begin
			p12_val = s_poll_clk;
		end
		default: begin
			p12_val = p12_test;
		end
		endcase
	end

	// serial out pin function, separate serial output wins
	always @* begin
		p13_drv = 1'b1;
		p13_val = 1'b0;
		p13_inv = serial_out_pin_invert;
		if (separate_serial_output) begin
			p13_drv = spi_sdo_en_i;
			p13_val = spi_sdo_i;
			p13_inv = 1'b0;
		end else begin
			case (serial_out_pin_function_select)
			`PMX_C3_HIZ: p13_drv = 1'b0;
			`PMX_C3_ZERO: p13_val = 1'b0;
			`PMX_C3_TWO: p13_val = s_tx_mod;
			`PMX_C3_THREE: p13_val = s_rx_ready | s_tx_ready;
			`PMX_C3_FOUR: p13_val = s_refclk_ready;
			`PMX_C3_FIVE: p13_val = s_lo_ready;
			`PMX_C3_SIX: p13_val = s_rx_ready;
			default: p13_val = s_tx_ready;
			endcase
		end
	end

	// data pin: rx data out, tx data in, else left undriven
	always @* begin
		p10_drv = 1'b0;
		p10_val = 1'b0;
		if (sep_rx_live && !sep_tx_live) begin
			p10_drv = 1'b1;
			p10_val = s_rx_data;
		end
	end

	// indicator pin: low for rx, high for tx, otherwise released
	always @* begin
		p14_drv = 1'b1;
		p14_val = 1'b0;
		case (indicator_pin_function_select)
		`PMX_C2_HIZ: begin
			p14_drv = 1'b0;
		end
		`PMX_C2_LOW: begin
			p14_val = 1'b0;
		end
		default: begin
			if (s_tx_active) begin
				p14_val = 1'b1;
			end else if (s_rx_active) begin
				p14_val = 1'b0;
			end else begin
				p14_drv = 1'b0;
			end
		end
		endcase
	end

	// tx data source and serial-line routing flags
	always @(posedge clk_i) begin
		if (rst_i) begin
			tx_data_o <= 1'b0;
			rx_on_serial_o <= 1'b0;
			tx_on_serial_o <= 1'b0;
		end else begin
			if (sep_tx_live) begin
				tx_data_o <= s_data_pin;
			end else begin
				tx_data_o <= s_serial_in;
			end
			rx_on_serial_o <= s_rx_active & ~separate_rx_lines;
			tx_on_serial_o <= s_tx_active & ~separate_tx_lines;
		end
	end

	// each pin leaves through its own registered driver
	pmx_pin u_data_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.drive_i(p10_drv),
		.val_i(p10_val),
		.inv_i(1'b0),
		.pin_o(data_pin_o),
		.pin_oe_o(data_pin_oe_o)
	);

	pmx_pin u_clock_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.drive_i(p12_drv),
		.val_i(p12_val),
		.inv_i(clock_pin_invert),
		.pin_o(clock_pin_o),
		.pin_oe_o(clock_pin_oe_o)
	);

	pmx_pin u_serial_out_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.drive_i(p13_drv),
		.val_i(p13_val),
		.inv_i(p13_inv),
		.pin_o(serial_out_pin_o),
		.pin_oe_o(serial_out_pin_oe_o)
	);

	pmx_pin u_indicator_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.drive_i(p14_drv),
		.val_i(p14_val),
		.inv_i(indicator_pin_invert),
		.pin_o(indicator_pin_o),
		.pin_oe_o(indicator_pin_oe_o)
	);
endmodule

// file: tb/pmx_port_mux_sva.sv
// checker for the port pin multiplexer, bound to its top module
// assumes register writes land at the edge where ack_o is high
`timescale 1ns/1ns
`include "pmx_consts.vh"
module pmx_port_mux_sva (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire ack_o,
	input wire spi_sdo_i,
	input wire spi_sdo_en_i,
	input wire clock_pin_o,
	input wire clock_pin_oe_o,
	input wire serial_out_pin_o,
	input wire serial_out_pin_oe_o,
	input wire indicator_pin_o,
	input wire indicator_pin_oe_o,
	input wire rx_on_serial_o,
	input wire tx_on_serial_o
);
	logic [7:0] p1_r;
	logic [7:0] p2_r;
	wire wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
	// shadow copies of the two port control registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			p1_r <= `PMX_RST_PORT_ONE;
			p2_r <= `PMX_RST_PORT_TWO;
		end else begin
			if (wr && adr_i[7:2] == `PMX_IDX_PORT_ONE)
				p1_r <= dat_i[7:0];
			if (wr && adr_i[7:2] == `PMX_IDX_PORT_TWO)
				p2_r <= dat_i[7:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_one: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_clk_zero: assert property (p1_r[3:1] == 3'h1 |->
		clock_pin_oe_o && clock_pin_o == p1_r[0])
		else $error("clock pin not constant zero");
	chk_ser_zero: assert property (!p2_r[7] &&
		p1_r[7:5] == 3'h1 |->
		serial_out_pin_oe_o && serial_out_pin_o == p1_r[4])
		else $error("serial out pin not constant zero");
	chk_sdo_prio: assert property (p2_r[7] |->
		serial_out_pin_oe_o == $past(spi_sdo_en_i) &&
		(!serial_out_pin_oe_o || serial_out_pin_o == $past(spi_sdo_i)))
		else $error("serial out pin not spi data");
	chk_ind_low: assert property (p2_r[2:1] == 2'h1 |->
		indicator_pin_oe_o && indicator_pin_o == p2_r[0])
		else $error("indicator pin not constant low");
	chk_rx_sep: assert property (rx_on_serial_o |-> !p2_r[6])
		else $error("rx on serial while separate");
	chk_tx_sep: assert property (tx_on_serial_o |-> !p2_r[5])
		else $error("tx on serial while separate");
endmodule
bind pmx_port_mux pmx_port_mux_sva i_pmx_port_mux_sva (.clk_i, .rst_i,
	.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .spi_sdo_i,
	.spi_sdo_en_i, .clock_pin_o, .clock_pin_oe_o, .serial_out_pin_o,
	.serial_out_pin_oe_o, .indicator_pin_o, .indicator_pin_oe_o,
	.rx_on_serial_o, .tx_on_serial_o);

// file: tb/pmx_host.sv
// host model on the far side of the data pin
// assumes the bench says when a separate transmit path is live
`timescale 1ns/1ns
module pmx_host (
	input wire clk_i,
	input wire drive_i,
	input wire bit_i,
	input wire dev_oe_i,
	input wire dev_i,
	output logic wire_o
);
	logic idle_r = 1'h0;
	// a released line has no level: show one that changes every cycle
	always @(posedge clk_i)
		idle_r <= ~idle_r;
	// transmit data is driven only while the separate path is live
	always_comb
		wire_o = dev_oe_i ? dev_i : drive_i ? bit_i : idle_r;
endmodule

// file: tb/testbench.sv
// self-checking bench for the port pin multiplexer
// assumes pins settle within six cycles of a write or input change
`timescale 1ns/1ns
`include "pmx_consts.vh"
module testbench;
	logic clk_i = 1'h0, rst_i = 1'h1, lclk = 1'h0, hen = 1'h0, hbit = 1'h0;
	logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic [7:0] adr_i = 8'h00, p1, p2;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, seed = 32'h21, q, r, r2, v;
	logic [28:0] in_r = 29'h0;
	logic [2:0] lh = 3'h0, c, t;
	logic tl, rl;
	logic [5:0] e;
	integer n_fail = 0, cmp_count = 0, cyc_n = 0, i;
	wire [31:0] dat_o;
	wire ack_o, data_pin_i, data_pin_o, data_pin_oe_o, clock_pin_o;
	wire clock_pin_oe_o, serial_out_pin_o, serial_out_pin_oe_o;
	wire indicator_pin_o, indicator_pin_oe_o, tx_data_o;
	wire rx_on_serial_o, tx_on_serial_o;
	wire [5:0] pins_s = {clock_pin_oe_o, clock_pin_o & clock_pin_oe_o,
		serial_out_pin_oe_o, serial_out_pin_o & serial_out_pin_oe_o,
		indicator_pin_oe_o, indicator_pin_o & indicator_pin_oe_o};
	wire [4:0] side_s = {data_pin_oe_o, data_pin_o & data_pin_oe_o,
		tx_data_o, rx_on_serial_o, tx_on_serial_o};
	pmx_port_mux i_pmx_port_mux (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
		.adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .tx_active_i(in_r[0]),
		.rx_active_i(in_r[1]), .tx_bit_clk_i(lclk), .rx_bit_clk_i(in_r[3]),
		.rx_data_i(in_r[4]), .clkgen_out_i(in_r[5]), .pll_fb_clk_i(in_r[6]),
		.poll_clk_i(in_r[7]), .tx_mod_i(in_r[8]), .rx_ready_i(in_r[9]),
		.tx_ready_i(in_r[10]), .reference_clock_ready_i(in_r[11]),
		.local_osc_ready_i(in_r[12]), .test_group_a_i(in_r[19:13]),
		.test_group_b_i(in_r[25:20]), .serial_data_in_i(in_r[26]),
		.spi_sdo_i(in_r[27]), .spi_sdo_en_i(in_r[28]), .data_pin_i,
		.data_pin_o, .data_pin_oe_o, .clock_pin_o, .clock_pin_oe_o,
		.serial_out_pin_o, .serial_out_pin_oe_o, .indicator_pin_o,
		.indicator_pin_oe_o, .tx_data_o, .rx_on_serial_o, .tx_on_serial_o);
	pmx_host i_pmx_host (.clk_i, .drive_i(hen), .bit_i(hbit),
		.dev_oe_i(data_pin_oe_o), .dev_i(data_pin_o), .wire_o(data_pin_i));
	always #25 clk_i = ~clk_i;
	always #200 lclk = ~lclk;
	// link clock as seen three clocks later at the pin
	always @(posedge clk_i)
		lh <= {lh[1:0], lclk};
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic [5:0] exp_pins(input logic [28:0] v, input logic [7:0] p1,
		input logic [7:0] p2, input logic [2:0] t);
		logic co, cv, so, sv, io, iv;
		co = 1'h1;
		so = 1'h1;
		case (p1[3:1])
			3'h0: co = 1'h0;
			3'h2: begin
				co = p2[5] & v[0] | p2[6] & v[1];
				cv = p2[5] & v[0] ? v[2] : v[3];
			end
			3'h3: cv = v[5];
			3'h4: cv = v[6];
			3'h5: cv = v[7];
			3'h6: cv = v[13 + t];
			3'h7: cv = t == 3'h2 ? v[7] : t == 3'h7 ? 1'h0 :
				t < 3'h2 ? v[20 + t] : v[19 + t];
			default: cv = 1'h0;
		endcase
		case (p1[7:5])
			3'h0: so = 1'h0;
			3'h2: sv = v[8];
			3'h3: sv = v[9] | v[10];
			3'h4: sv = v[11];
			3'h5: sv = v[12];
			3'h6: sv = v[9];
			3'h7: sv = v[10];
			default: sv = 1'h0;
		endcase
		sv = sv ^ p1[4];
		if (p2[7]) begin
			so = v[28];
			sv = v[27];
		end
		io = p2[2] ? v[0] | v[1] : p2[1];
		iv = (p2[2] & v[0]) ^ p2[0];
		return {co, co & (cv ^ p1[0]), so, so & sv, io, io & iv};
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wb(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] rd);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'h1);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 4000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(8'h44, 1'h0, 8'h00, q);
		chk("port one", 32'(`PMX_RST_PORT_ONE), q);
		wb(8'h48, 1'h0, 8'h00, q);
		chk("port two", 32'(`PMX_RST_PORT_TWO), q);
		wb(8'hD4, 1'h0, 8'h00, q);
		chk("test select", 32'(`PMX_RST_TEST_SEL), q);
		wb(8'h00, 1'h1, 8'hFF, q);
		wb(8'h00, 1'h0, 8'h00, q);
		chk("unmapped", 32'h0, q);
		for (i = 0; i < 80; i++) begin
			r = rnd();
			r2 = rnd();
			in_r <= r[28:0];
			c = i < 64 ? i[5:3] : 3'h2;
			t = i < 64 ? i[2:0] : r[31:29];
			if (c == 3'h6 && t == 3'h7)
				t = 3'h6;
			p1 = {r2[7:4], c, r2[0]};
			p2 = {r2[15:13], 2'h0, r2[10:8]};
			tl = p2[5] & r[0];
			rl = p2[6] & r[1];
			hbit <= r2[16];
			hen <= tl;
			wb(8'hD4, 1'h1, {1'h0, t, 4'h0}, q);
			wb(8'h48, 1'h1, p2, q);
			wb(8'h44, 1'h1, p1, q);
			wb(8'h44, 1'h0, 8'h00, q);
			chk("port one", 32'(p1), q);
			repeat (6) @(posedge clk_i);
			v = r;
			v[2] = lh[2];
			e = exp_pins(v[28:0], p1, p2, t);
			chk("clock pin", 32'(e[5:4]), 32'(pins_s[5:4]));
			chk("serial out pin", 32'(e[3:2]), 32'(pins_s[3:2]));
			chk("indicator pin", 32'(e[1:0]), 32'(pins_s[1:0]));
			chk("data side", 32'({rl & !tl, rl & !tl & r[4],
				tl ? r2[16] : r[26], r[1] & !p2[6], r[0] & !p2[5]}),
				32'(side_s));
			wb(8'hD8, 1'h0, 8'h00, q);
			chk("status", {24'h0, e[1], e[3], e[5], rl & !tl, rl, tl,
				r[1], r[0]}, q);
		end
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		chk("reset pins", 32'h0, 32'({pins_s, side_s}));
		rst_i <= 1'h0;
		wb(8'h44, 1'h0, 8'h00, q);
		chk("port one", 32'(`PMX_RST_PORT_ONE), q);
		stop_test();
	end
endmodule
